// ==== pkg/usp_pkg.sv ====
// package: register map, field layout and codes for the suspend/pin-mode block
package usp_pkg;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;  // host requests, bus events
   localparam logic [7:0]  ADDR_CFG      = 8'h04;  // configuration memory image
   localparam logic [7:0]  ADDR_GPDIR    = 8'h08;  // gp pin directions
   localparam logic [7:0]  ADDR_GPOUT    = 8'h0c;  // gp pin output levels
   localparam logic [7:0]  ADDR_STATUS   = 8'h10;  // state and sampled inputs
   // ctrl bits (write one to signal an event; CTRL_DTR and CTRL_RTS hold the written level)
   localparam int CTRL_SUSP_DET  = 0;
   localparam int CTRL_RES_DET   = 1;
   localparam int CTRL_RES_GEN   = 2;
   localparam int CTRL_BUS_RST   = 3;
   localparam int CTRL_CFG_DONE  = 4;
   localparam int CTRL_DTR       = 5;
   localparam int CTRL_RTS       = 6;
   // cfg bits
   localparam int CFG_SUSP_HIGH  = 0;  // suspend indication active-high
   localparam int CFG_STD_MODEM  = 1;  // standard port modem mode
   localparam int CFG_ENH_MODEM  = 2;  // enhanced port modem mode
   localparam int CFG_SUSP_LVL0  = 3;  // gp0 level in suspend
   localparam int CFG_SUSP_LVL1  = 4;
   localparam int CFG_SUSP_OD    = 5;  // open-drain in suspend
   localparam int CFG_PROG_DONE  = 6;  // set by hardware on first write
   localparam int CFG_W          = 7;
   localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
   // status bits
   localparam int ST_SUSP        = 0;
   localparam int ST_CONFIGURED  = 1;
   localparam int ST_CTS         = 2;
   localparam int ST_RI          = 3;
   localparam int ST_DCD         = 4;
   localparam int ST_DSR         = 5;
   localparam int ST_GP0         = 6;
   localparam int ST_GP1         = 7;
   localparam int ST_SERIAL_IN   = 8;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      USP_ACTIVE = 2'b01,
      USP_SUSP   = 2'b10
   } usp_state_t;
endpackage

// ==== hdl/usp_top.sv ====
// suspend indication, pin-mode routing and register slave of the usb bridge
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module usp_top (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        std_port_clear_to_send_n,
   output logic             std_port_suspend_o,
   output logic             std_port_suspend_oe,
   output logic             enh_port_suspend_o,
   output logic             enh_port_suspend_oe,
   input  wire logic        enh_port_ring_indicator_n,
   input  wire logic        enh_port_carrier_detect_n,
   input  wire logic        enh_port_data_set_ready_n,
   output logic             enh_port_terminal_ready_n,
   input  wire logic        enh_port_gp_pin0_i,
   output logic             enh_port_gp_pin0_o,
   output logic             enh_port_gp_pin0_oe,
   input  wire logic        enh_port_gp_pin1_i,
   output logic             enh_port_gp_pin1_o,
   output logic             enh_port_gp_pin1_oe,
   input  wire logic        enh_port_serial_in,
   output logic             enh_port_serial_out,
   input  wire logic        enh_tx_data,
   output logic             enh_rx_data,
   output logic             enh_port_request_to_send_n
);
   import usp_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      usp_state_t             state;
      logic                   configured;
      logic [1:0]             gpDir;
      logic [1:0]             gpOut;
      logic                   dtr;
      logic                   rts;
      logic                   awHeld;
      logic [7:0]             awAddr;
      logic                   wHeld;
      logic [31:0]            wData;
      logic [3:0]             wStrb;
      logic                   bValid;
      logic [1:0]             bResp;
      logic                   rValid;
      logic [31:0]            rData;
      logic [1:0]             rResp;
      logic [5:0]             sync1;
      logic [5:0]             sync2;
      logic                   serialOut;
      logic                   serIn1;
      logic                   serIn2;
      logic                   stdSuspO;
      logic                   stdSuspOe;
      logic                   enhSuspO;
      logic                   enhSuspOe;
      logic [1:0]             gpO;
      logic [1:0]             gpOe;
      logic                   termRdyN;
      logic                   rtsN;
   } usp_regs_t;

   usp_regs_t st_ff;
   usp_regs_t nxt_st;

   localparam usp_regs_t REGS_RESET = '{
      state: USP_ACTIVE, configured: 1'b0, gpDir: 2'b00, gpOut: 2'b00,
      dtr: 1'b0, rts: 1'b0, awHeld: 1'b0, awAddr: 8'h00, wHeld: 1'b0,
      wData: 32'h0, wStrb: 4'h0, bValid: 1'b0, bResp: RESP_OKAY,
      rValid: 1'b0, rData: 32'h0, rResp: RESP_OKAY, sync1: 6'h3f,
      sync2: 6'h3f, serialOut: 1'b1, serIn1: 1'b1, serIn2: 1'b1,
      stdSuspO: 1'b1, stdSuspOe: 1'b0, enhSuspO: 1'b1, enhSuspOe: 1'b0,
      gpO: 2'b00, gpOe: 2'b00, termRdyN: 1'b1, rtsN: 1'b1};

   // decoded address check, shared by both channels
   function automatic logic addrMapped(input logic [7:0] a);
      addrMapped = (a == ADDR_CTRL) || (a == ADDR_CFG) ||
                   (a == ADDR_GPDIR) || (a == ADDR_GPOUT) ||
                   (a == ADDR_STATUS);
   endfunction

   // indication level: active-low unless the memory asks for high
   function automatic logic suspLevel(input logic on, input logic hi);
      suspLevel = hi ? on : !on;
   endfunction

   // synchronised pin inputs: cts, ri, dcd, dsr, gp0, gp1
   logic ctsN;
   logic riN;
   logic dcdN;
   logic dsrN;
   logic [1:0] gpIn;
   assign ctsN = st_ff.sync2[0];
   assign riN  = st_ff.sync2[1];
   assign dcdN = st_ff.sync2[2];
   assign dsrN = st_ff.sync2[3];
   assign gpIn = st_ff.sync2[5:4];

   logic enhModem;
   logic stdModem;
   logic suspActive;
   logic doWrite;
   logic [31:0] statusWord;
   logic suspHigh;
   logic stdOn;
   logic enhOn;
   logic [CFG_W-1:0] cfg_ff = CFG_RESET;
   logic [CFG_W-1:0] nxt_cfg;
   assign enhModem = cfg_ff[CFG_ENH_MODEM];
   assign stdModem = cfg_ff[CFG_STD_MODEM];
   // asserted while suspended or until enumeration finishes
   assign suspActive = (st_ff.state == USP_SUSP) || !st_ff.configured;
   assign doWrite = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
   assign suspHigh = cfg_ff[CFG_SUSP_HIGH];
   assign stdOn = !stdModem && suspActive;
   assign enhOn = !enhModem && suspActive;

   always_comb begin
      statusWord = 32'h0;
      statusWord[ST_SUSP]       = (st_ff.state == USP_SUSP);
      statusWord[ST_CONFIGURED] = st_ff.configured;
      statusWord[ST_CTS]        = !ctsN;
      statusWord[ST_RI]         = enhModem && !riN;
      statusWord[ST_DCD]        = enhModem && !dcdN;
      statusWord[ST_DSR]        = enhModem && !dsrN;
      statusWord[ST_GP0]        = !enhModem && gpIn[0];
      statusWord[ST_GP1]        = !enhModem && gpIn[1];
      statusWord[ST_SERIAL_IN]  = st_ff.serIn2;
   end

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_cfg = cfg_ff;
      nxt_st.sync1 = {enh_port_gp_pin1_i, enh_port_gp_pin0_i,
                      enh_port_data_set_ready_n, enh_port_carrier_detect_n,
                      enh_port_ring_indicator_n, std_port_clear_to_send_n};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.serialOut = enh_tx_data;
      if (s_axi_awvalid && !st_ff.awHeld) begin
         nxt_st.awHeld = 1'b1;
         nxt_st.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.wHeld) begin
         nxt_st.wHeld = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (st_ff.bValid && s_axi_bready)
         nxt_st.bValid = 1'b0;
      if (doWrite) begin
         nxt_st.awHeld = 1'b0;
         nxt_st.wHeld  = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp  = addrMapped(st_ff.awAddr) ? RESP_OKAY : RESP_SLVERR;
         if (st_ff.wStrb[0]) begin
            case (st_ff.awAddr)
               ADDR_CTRL: begin
                  nxt_st.dtr = st_ff.wData[CTRL_DTR];
                  nxt_st.rts = st_ff.wData[CTRL_RTS];
                  if (st_ff.wData[CTRL_CFG_DONE])
                     nxt_st.configured = 1'b1;
               end
               ADDR_CFG: begin
                  // whole image is one-time: later writes are dropped
                  if (!cfg_ff[CFG_PROG_DONE]) begin
                     nxt_cfg = st_ff.wData[CFG_W-1:0];
                     nxt_cfg[CFG_PROG_DONE] = 1'b1;
                  end
               end
               ADDR_GPDIR: nxt_st.gpDir = st_ff.wData[1:0];
               ADDR_GPOUT: nxt_st.gpOut = st_ff.wData[1:0];
               default: ;
            endcase
         end
      end
      // suspend state machine; a bus reset wins over a suspend request
      case (st_ff.state)
         USP_ACTIVE: begin
            if (doWrite && st_ff.awAddr == ADDR_CTRL && st_ff.wStrb[0] &&
                st_ff.wData[CTRL_SUSP_DET] && !st_ff.wData[CTRL_BUS_RST])
               nxt_st.state = USP_SUSP;
         end
         USP_SUSP: begin
            if (doWrite && st_ff.awAddr == ADDR_CTRL && st_ff.wStrb[0] &&
                (st_ff.wData[CTRL_RES_DET] || st_ff.wData[CTRL_RES_GEN] ||
                 st_ff.wData[CTRL_BUS_RST]))
               nxt_st.state = USP_ACTIVE;
         end
         default: nxt_st.state = USP_ACTIVE;
      endcase
      // read channel: one read at a time, answered the cycle after
      if (st_ff.rValid && s_axi_rready)
         nxt_st.rValid = 1'b0;
      if (s_axi_arvalid && !st_ff.rValid) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rResp  = addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         nxt_st.rData  = 32'h0;
         case (s_axi_araddr)
            ADDR_CTRL: begin
               nxt_st.rData[CTRL_CFG_DONE] = st_ff.configured;
               nxt_st.rData[CTRL_DTR]      = st_ff.dtr;
               nxt_st.rData[CTRL_RTS]      = st_ff.rts;
            end
            ADDR_CFG:    nxt_st.rData[CFG_W-1:0] = cfg_ff;
            ADDR_GPDIR:  nxt_st.rData[1:0] = st_ff.gpDir;
            ADDR_GPOUT:  nxt_st.rData[1:0] = st_ff.gpOut;
            ADDR_STATUS: nxt_st.rData = statusWord;
            default: ;
         endcase
      end
      // pins leave flip-flops; a mode change shows one cycle later
      nxt_st.serIn1    = enh_port_serial_in;
      nxt_st.serIn2    = st_ff.serIn1;
      nxt_st.stdSuspOe = !stdModem;
      nxt_st.stdSuspO  = suspLevel(stdOn, suspHigh);
      nxt_st.enhSuspOe = !enhModem;
      nxt_st.enhSuspO  = suspLevel(enhOn, suspHigh);
      nxt_st.termRdyN  = !(enhModem && st_ff.dtr);
      nxt_st.rtsN      = !st_ff.rts;
      for (int i = 0; i < 2; i++) begin
         if (enhModem) begin
            nxt_st.gpO[i]  = 1'b0;
            nxt_st.gpOe[i] = 1'b0;
         end else if (st_ff.state == USP_SUSP) begin
            // open-drain high is left to the pull-up, so not driven
            nxt_st.gpO[i]  = cfg_ff[CFG_SUSP_LVL0 + i];
            nxt_st.gpOe[i] = !(cfg_ff[CFG_SUSP_OD] &&
                               cfg_ff[CFG_SUSP_LVL0 + i]);
         end else begin
            nxt_st.gpO[i]  = st_ff.gpOut[i];
            nxt_st.gpOe[i] = st_ff.gpDir[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= REGS_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // no reset: the image stands for one-time storage and must outlive
   // a device reset; only power-up gives the blank value
   always_ff @(posedge ref_clk) begin
      cfg_ff <= nxt_cfg;
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign s_axi_awready              = !st_ff.awHeld;
   assign s_axi_wready               = !st_ff.wHeld;
   assign s_axi_bvalid               = st_ff.bValid;
   assign s_axi_bresp                = st_ff.bResp;
   assign s_axi_arready              = !st_ff.rValid;
   assign s_axi_rvalid               = st_ff.rValid;
   assign s_axi_rdata                = st_ff.rData;
   assign s_axi_rresp                = st_ff.rResp;
   assign std_port_suspend_o         = st_ff.stdSuspO;
   assign std_port_suspend_oe        = st_ff.stdSuspOe;
   assign enh_port_suspend_o         = st_ff.enhSuspO;
   assign enh_port_suspend_oe        = st_ff.enhSuspOe;
   assign enh_port_terminal_ready_n  = st_ff.termRdyN;
   assign enh_port_gp_pin0_o         = st_ff.gpO[0];
   assign enh_port_gp_pin0_oe        = st_ff.gpOe[0];
   assign enh_port_gp_pin1_o         = st_ff.gpO[1];
   assign enh_port_gp_pin1_oe        = st_ff.gpOe[1];
   assign enh_port_serial_out        = st_ff.serialOut;
   assign enh_rx_data                = st_ff.serIn2;
   assign enh_port_request_to_send_n = st_ff.rtsN;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   a_susp_shown: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (st_ff.state == USP_SUSP && !stdModem) |=>
      (std_port_suspend_o == $past(suspHigh)))
      else $error("suspend indication missing while suspended");

   a_exit_clear: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (st_ff.state == USP_ACTIVE && st_ff.configured && !stdModem) |=>
      (std_port_suspend_o == !$past(suspHigh)))
      else $error("suspend indication left on after exit");

   a_unconf_held: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      (!st_ff.configured && !enhModem) |=>
      (enh_port_suspend_o == $past(suspHigh)))
      else $error("suspend indication dropped before configuration");

   a_modem_quiet: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      enhModem |=>
      (!enh_port_suspend_oe && !enh_port_gp_pin0_oe && !enh_port_gp_pin1_oe))
      else $error("shared pin driven in modem mode");

   a_cfg_once: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      cfg_ff[CFG_PROG_DONE] |=>
      (cfg_ff == $past(cfg_ff)))
      else $error("programmed memory image changed");

   a_term_ready: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      enhModem |=>
      (enh_port_terminal_ready_n == !$past(st_ff.dtr)))
      else $error("terminal-ready output not active-low");

   a_rts_low: assert property (@(posedge ref_clk)
      disable iff (!rstn)
      st_ff.rts |=>
      (enh_port_request_to_send_n == 1'b0))
      else $error("request-to-send output not active-low");
endmodule

// ==== tb/usp_far_model.sv ====
// far-side model: modem-control lines and gp pin resolution
`timescale 1ns/1ps
module usp_far_model (
   input  wire logic modemAct,
   input  wire logic gp1Drive,
   input  wire logic enh_port_gp_pin0_o,
   input  wire logic enh_port_gp_pin0_oe,
   input  wire logic enh_port_gp_pin1_o,
   input  wire logic enh_port_gp_pin1_oe,
   output logic      std_port_clear_to_send_n,
   output logic      enh_port_ring_indicator_n,
   output logic      enh_port_carrier_detect_n,
   output logic      enh_port_data_set_ready_n,
   output logic      enh_port_gp_pin0_i,
   output logic      enh_port_gp_pin1_i
);
   assign std_port_clear_to_send_n  = ~modemAct;
   assign enh_port_ring_indicator_n = ~modemAct;
   assign enh_port_carrier_detect_n = ~modemAct;
   assign enh_port_data_set_ready_n = ~modemAct;
   // released gp0 pin shows the inverse, so a stale level never reads right; released gp1 shows gp1Drive
   assign enh_port_gp_pin0_i = enh_port_gp_pin0_oe ? enh_port_gp_pin0_o
                                                   : ~enh_port_gp_pin0_o;
   assign enh_port_gp_pin1_i = enh_port_gp_pin1_oe ? enh_port_gp_pin1_o
                                                   : gp1Drive;
endmodule

// ==== tb/tb_usb_suspend_pin_function_control.sv ====
// bench: suspend indication and pin roles checked over the register bus
`timescale 1ns/1ps
module tb_usb_suspend_pin_function_control;
   import usp_pkg::*;
   logic        ref_clk = 1'h0, rstn = 1'h0, enh_tx_data = 1'h0;
   logic        enh_port_serial_in = 1'h0, modemAct = 1'h0, gp1Drive = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_rvalid, std_port_clear_to_send_n, std_port_suspend_o;
   logic        std_port_suspend_oe, enh_port_suspend_o, enh_port_suspend_oe;
   logic        enh_port_ring_indicator_n, enh_port_carrier_detect_n;
   logic        enh_port_data_set_ready_n, enh_port_terminal_ready_n;
   logic        enh_port_gp_pin0_i, enh_port_gp_pin0_o, enh_port_gp_pin0_oe;
   logic        enh_port_gp_pin1_i, enh_port_gp_pin1_o, enh_port_gp_pin1_oe;
   logic        enh_port_serial_out, enh_rx_data, enh_port_request_to_send_n;
   int          n_errors = 0, n_tests = 0;
   localparam logic [31:0] SUS = 32'h1 << ST_SUSP;
   localparam int EXITS[3] = '{CTRL_RES_DET, CTRL_RES_GEN, CTRL_BUS_RST};
   usp_top u_dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .std_port_clear_to_send_n, .std_port_suspend_o, .std_port_suspend_oe,
      .enh_port_suspend_o, .enh_port_suspend_oe, .enh_port_ring_indicator_n,
      .enh_port_carrier_detect_n, .enh_port_data_set_ready_n,
      .enh_port_terminal_ready_n, .enh_port_gp_pin0_i, .enh_port_gp_pin0_o,
      .enh_port_gp_pin0_oe, .enh_port_gp_pin1_i, .enh_port_gp_pin1_o,
      .enh_port_gp_pin1_oe, .enh_port_serial_in, .enh_port_serial_out,
      .enh_tx_data, .enh_rx_data, .enh_port_request_to_send_n);
   usp_far_model u_far (.modemAct, .gp1Drive, .enh_port_gp_pin0_o,
      .enh_port_gp_pin0_oe, .enh_port_gp_pin1_o, .enh_port_gp_pin1_oe,
      .std_port_clear_to_send_n, .enh_port_ring_indicator_n,
      .enh_port_carrier_detect_n, .enh_port_data_set_ready_n,
      .enh_port_gp_pin0_i, .enh_port_gp_pin1_i);
   always #2 ref_clk = ~ref_clk;
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic pin(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   // pin outputs have no handshake, so each write leaves time to settle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
      idle(4);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      chk(s_axi_rdata & m, e);
      idle(1);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_errors++;
      results();
   end
   initial begin
      idle(5);
      pin(std_port_suspend_oe, 1'h0);
      pin(enh_port_suspend_oe, 1'h0);
      idle(5);
      rstn <= 1'h1;
      idle(4);
      pin(std_port_suspend_oe, 1'h1);
      pin(std_port_suspend_o, 1'h0);
      pin(enh_port_suspend_o, 1'h0);
      rd(ADDR_CFG, 32'h7f, 32'h0, RESP_OKAY);
      $display("test reset finished");
      modemAct <= 1'h1;
      gp1Drive <= 1'h1;
      wr(ADDR_GPDIR, 32'h1);
      wr(ADDR_GPOUT, 32'h3);
      pin(enh_port_gp_pin0_oe, 1'h1);
      pin(enh_port_gp_pin0_o, 1'h1);
      pin(enh_port_gp_pin1_oe, 1'h0);
      rd(ADDR_STATUS, 32'hd4, 32'hc4, RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
         enh_tx_data <= ~i[0];
         enh_port_serial_in <= ~i[0];
         idle(3);
         pin(enh_port_serial_out, ~i[0]);
         pin(enh_rx_data, ~i[0]);
      end
      $display("test pins finished");
      wr(ADDR_CTRL, 32'h1 << CTRL_CFG_DONE);
      pin(std_port_suspend_o, 1'h1);
      foreach (EXITS[k]) begin
         wr(ADDR_CTRL, 32'h1 << CTRL_SUSP_DET);
         pin(std_port_suspend_o, 1'h0);
         pin(enh_port_suspend_o, 1'h0);
         pin(enh_port_gp_pin0_o, 1'h0);
         pin(enh_port_gp_pin0_oe, 1'h1);
         pin(enh_port_gp_pin1_o, 1'h0);
         rd(ADDR_STATUS, SUS, SUS, RESP_OKAY);
         wr(ADDR_CTRL, 32'h1 << EXITS[k]);
         rd(ADDR_STATUS, SUS, 32'h0, RESP_OKAY);
         pin(std_port_suspend_o, 1'h1);
      end
      $display("test suspend finished");
      wr(ADDR_CFG, 32'h5);
      wr(ADDR_CTRL, 32'h1 << CTRL_CFG_DONE);
      rd(ADDR_CFG, 32'h47, 32'h45, RESP_OKAY);
      pin(std_port_suspend_o, 1'h0);
      pin(enh_port_suspend_oe, 1'h0);
      rd(ADDR_STATUS, 32'h3c, 32'h3c, RESP_OKAY);
      wr(ADDR_CTRL, 32'h60);
      pin(enh_port_terminal_ready_n, 1'h0);
      pin(enh_port_request_to_send_n, 1'h0);
      wr(ADDR_CTRL, 32'h1 << CTRL_SUSP_DET);
      pin(std_port_suspend_o, 1'h1);
      wr(ADDR_CFG, 32'h2);
      rd(ADDR_CFG, 32'h7, 32'h5, RESP_OKAY);
      rd(8'h14, 32'h0, 32'h0, RESP_SLVERR);
      rstn <= 1'h0;
      idle(2);
      pin(std_port_suspend_oe, 1'h0);
      rstn <= 1'h1;
      idle(4);
      rd(ADDR_CFG, 32'h47, 32'h45, RESP_OKAY);
      pin(std_port_suspend_o, 1'h1);
      $display("test config finished");
      results();
   end
endmodule
